// >>> hdl/srtc_pkg.sv
// constants and types for the serial clock/calendar access block
package srtc_pkg;
   // ------------------------------------------------
   // timing
   // ------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_PERIOD_NS = 10_000_000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int REC_TIME_NS = 1_000_000;
   localparam int REC_CYCLES = REC_TIME_NS / CLK_PERIOD_NS;
   // ------------------------------------------------
   // serial link layout
   // ------------------------------------------------
   localparam int CMD_DIR_BIT = 7;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [5:0] CLK_ADDR_LAST = 6'h07;
   // ------------------------------------------------
   // clock register bytes and bits
   // ------------------------------------------------
   localparam int IDX_HUND = 0;
   localparam int IDX_SEC = 1;
   localparam int IDX_MIN = 2;
   localparam int IDX_HOUR = 3;
   localparam int IDX_DOW = 4;
   localparam int IDX_DATE = 5;
   localparam int IDX_MONTH = 6;
   localparam int IDX_YEAR = 7;
   localparam int OSC_STOP_BIT = 7;
   localparam int CENT_EN_BIT = 7;
   localparam int CENT_FLAG_BIT = 6;
   localparam logic [63:0] TIME_RESET = 64'h0001_0101_0000_0000;
   // ------------------------------------------------
   // register bus map
   // ------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam int CTRL_LINK_EN = 0;
   localparam logic CTRL_LINK_EN_RST = 1'h1;
   localparam int STAT_PTR_LSB = 0;
   localparam int STAT_FREEZE = 6;
   localparam int STAT_BUSY = 7;
   localparam int STAT_WRITE = 8;
   localparam int STAT_LOCK = 9;
   localparam int STAT_OSC_STOP = 10;
   localparam int STAT_CENT_FLAG = 11;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {SPI_IDLE, SPI_CMD, SPI_WRITE, SPI_READ} srtc_spi_state_t;
endpackage

// >>> hdl/srtc_ram.sv
// 64 x 8 storage with registered read data
`timescale 1ns/1ps
module srtc_ram
   import srtc_pkg::*;
(
   input wire logic aclk,
   input wire logic we,
   input wire logic [5:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [5:0] raddr,
   output logic [7:0] rdata_q
);
   logic [7:0] mem [64];

   always_ff @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end
endmodule // srtc_ram

// >>> hdl/srtc_timekeep.sv
// internal time counters, bcd, with divider chain
`timescale 1ns/1ps
module srtc_timekeep
   import srtc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic [2:0] load_idx,
   input wire logic [7:0] load_data,
   output logic [63:0] time_q
);
   logic [31:0] div_q, div_d;
   logic [63:0] time_d;
   logic tick;

   // bcd step: {carry, next}
   function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                           input logic [7:0] base);
      if (v >= top) begin
         bcd_inc = {1'b1, base};
      end else if (v[3:0] == 4'h9) begin
         bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {1'b0, v + 8'h01};
      end
   endfunction

   assign tick = (div_q == 32'(TICK_CYC - 1));

   always_comb begin
      logic [8:0] h, s, m, hr, dt, mo, yr;
      logic [7:0] mlen, t3, yv;
      logic leap;
      h = '0;
      s = '0;
      m = '0;
      hr = '0;
      dt = '0;
      mo = '0;
      yr = '0;
      t3 = time_q[IDX_HOUR*8 +: 8];
      yv = time_q[IDX_YEAR*8 +: 8];
      leap = yv[4] ? (yv[3:0] == 4'h2 || yv[3:0] == 4'h6) :
                     (yv[3:0] == 4'h0 || yv[3:0] == 4'h4 || yv[3:0] == 4'h8);
      unique case (time_q[IDX_MONTH*8 +: 8])
         8'h02: mlen = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: mlen = 8'h30;
         default: mlen = 8'h31;
      endcase
      div_d = tick ? 32'h0 : div_q + 32'h1;
      time_d = time_q;
      if (tick && !time_q[IDX_SEC*8 + OSC_STOP_BIT]) begin
         h = bcd_inc(time_q[7:0], 8'h99, 8'h00);
         time_d[7:0] = h[7:0];
         if (h[8]) begin
            s = bcd_inc({1'b0, time_q[14:8]}, 8'h59, 8'h00);
            time_d[14:8] = s[6:0];
         end
         if (s[8]) begin
            m = bcd_inc({1'b0, time_q[22:16]}, 8'h59, 8'h00);
            time_d[22:16] = m[6:0];
         end
         if (m[8]) begin
            hr = bcd_inc({2'h0, t3[5:0]}, 8'h23, 8'h00);
            time_d[29:24] = hr[5:0];
         end
         if (hr[8]) begin
            time_d[34:32] = (time_q[34:32] >= 3'h7) ? 3'h1 : time_q[34:32] + 3'h1;
            dt = bcd_inc(time_q[47:40], mlen, 8'h01);
            time_d[47:40] = dt[7:0];
         end
         if (dt[8]) begin
            mo = bcd_inc(time_q[55:48], 8'h12, 8'h01);
            time_d[55:48] = mo[7:0];
         end
         if (mo[8]) begin
            yr = bcd_inc(yv, 8'h99, 8'h00);
            time_d[63:56] = yr[7:0];
         end
         if (yr[8] && t3[CENT_EN_BIT]) begin
            time_d[IDX_HOUR*8 + CENT_FLAG_BIT] = ~t3[CENT_FLAG_BIT];
         end
      end
      if (load) begin
         time_d[load_idx*8 +: 8] = load_data;
         div_d = 32'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= 32'h0;
         time_q <= TIME_RESET;
      end else begin
         div_q <= div_d;
         time_q <= time_d;
      end
   end
endmodule // srtc_timekeep

// >>> hdl/srtc_access.sv
// serial slave access to clock/calendar and 56-byte memory, with register bus
`timescale 1ns/1ps
module srtc_access
   import srtc_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int REC_CYC = REC_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   input wire logic power_fail,
   input wire logic on_battery,
   output logic rst_out,
   output logic rst_out_oe
);
   // ------------------------------------------------
   // power supervision
   // ------------------------------------------------
   logic [31:0] rec_q, rec_d;
   logic rst_oe_d;
   logic lockout;

   assign lockout = power_fail || on_battery || (rec_q != 32'h0);

   always_comb begin
      rec_d = rec_q;
      if (power_fail || on_battery) begin
         rec_d = 32'(REC_CYC);
      end else if (rec_q != 32'h0) begin
         rec_d = rec_q - 32'h1;
      end
      rst_oe_d = lockout && !on_battery;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rec_q <= 32'h0;
         rst_out_oe <= 1'b0;
      end else begin
         rec_q <= rec_d;
         rst_out_oe <= rst_oe_d;
      end
   end

   assign rst_out = 1'b0;

   // ------------------------------------------------
   // serial engine
   // ------------------------------------------------
   srtc_spi_state_t st_q, st_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d, tx_q, tx_d, rd_byte, ram_rdata;
   logic [5:0] ptr_q, ptr_d;
   logic [1:0] ld_q, ld_d;
   logic [63:0] user_q, user_d, tk_time;
   logic sck_q, cs_q, cs_eff_n, so_d, oe_d, rise, fall, wr_en, freeze;
   logic ctrl_en_q, ctrl_en_d;

   assign cs_eff_n = spi_cs_n || lockout || !ctrl_en_q;
   assign rise = spi_sck && !sck_q;
   assign fall = !spi_sck && sck_q;
   assign freeze = (st_q == SPI_WRITE || st_q == SPI_READ) && (ptr_q <= CLK_ADDR_LAST);
   assign rd_byte = (ptr_q <= CLK_ADDR_LAST) ? user_q[ptr_q[2:0]*8 +: 8] : ram_rdata;

   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      tx_d = tx_q;
      ptr_d = ptr_q;
      ld_d = {ld_q[0], 1'b0};
      so_d = serial_out;
      oe_d = serial_out_oe;
      wr_en = 1'b0;
      if (cs_eff_n) begin
         st_d = SPI_IDLE;
         oe_d = 1'b0;
         if (lockout) begin
            ptr_d = 6'h00;
         end
      end else if (cs_q) begin
         st_d = SPI_CMD;
         bit_d = 3'h0;
      end else begin
         if (rise && st_q != SPI_IDLE) begin
            sh_d = {sh_q[6:0], serial_in};
            bit_d = bit_q + 3'h1;
            if (bit_q == LAST_BIT) begin
               unique case (st_q)
                  SPI_CMD: begin
                     ptr_d = sh_d[5:0];
                     st_d = sh_d[CMD_DIR_BIT] ? SPI_WRITE : SPI_READ;
                     ld_d[0] = 1'b1;
                  end
                  SPI_WRITE: begin
                     wr_en = 1'b1;
                     ptr_d = ptr_q + 6'h01;
                  end
                  SPI_READ: begin
                     ptr_d = ptr_q + 6'h01;
                     ld_d[0] = 1'b1;
                  end
                  SPI_IDLE: st_d = SPI_IDLE;
               endcase
            end
         end
         if (fall && st_q == SPI_READ) begin
            so_d = tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
            oe_d = !on_battery;
         end
      end
      if (ld_q[1]) begin
         tx_d = rd_byte;
      end
   end

   always_comb begin
      user_d = freeze ? user_q : tk_time;
      if (wr_en && ptr_q <= CLK_ADDR_LAST) begin
         user_d[ptr_q[2:0]*8 +: 8] = sh_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= SPI_IDLE;
         bit_q <= 3'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 6'h00;
         ld_q <= 2'h0;
         sck_q <= 1'b0;
         cs_q <= 1'b1;
         serial_out <= 1'b0;
         serial_out_oe <= 1'b0;
         user_q <= TIME_RESET;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         tx_q <= tx_d;
         ptr_q <= ptr_d;
         ld_q <= ld_d;
         sck_q <= spi_sck;
         cs_q <= spi_cs_n;
         serial_out <= so_d;
         serial_out_oe <= oe_d;
         user_q <= user_d;
      end
   end

   srtc_ram u_ram (
      .aclk(aclk),
      .we(wr_en && ptr_q > CLK_ADDR_LAST),
      .waddr(ptr_q),
      .wdata(sh_d),
      .raddr(ptr_q),
      .rdata_q(ram_rdata)
   );

   srtc_timekeep #(.TICK_CYC(TICK_CYC)) u_time (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(wr_en && ptr_q <= CLK_ADDR_LAST),
      .load_idx(ptr_q[2:0]),
      .load_data(sh_d),
      .time_q(tk_time)
   );

   // ------------------------------------------------
   // register bus slave
   // ------------------------------------------------
   logic awh_q, awh_d, wh_q, wh_d, awr_d, wr_d, bv_d, arr_d, rv_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rdat_d, status;
   logic ws_q, ws_d;
   logic [1:0] br_d, rr_d;

   always_comb begin
      status = 32'h0;
      status[STAT_PTR_LSB +: 6] = ptr_q;
      status[STAT_FREEZE] = freeze;
      status[STAT_BUSY] = (st_q != SPI_IDLE);
      status[STAT_WRITE] = (st_q == SPI_WRITE);
      status[STAT_LOCK] = lockout;
      status[STAT_OSC_STOP] = tk_time[IDX_SEC*8 + OSC_STOP_BIT];
      status[STAT_CENT_FLAG] = tk_time[IDX_HOUR*8 + CENT_FLAG_BIT];
   end

   always_comb begin
      awh_d = awh_q;
      awa_d = awa_q;
      wh_d = wh_q;
      wd_d = wd_q;
      ws_d = ws_q;
      ctrl_en_d = ctrl_en_q;
      bv_d = s_axi_bvalid && !s_axi_bready;
      br_d = s_axi_bresp;
      rv_d = s_axi_rvalid && !s_axi_rready;
      rdat_d = s_axi_rdata;
      rr_d = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         awh_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wh_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb[0];
      end
      if (awh_q && wh_q && !s_axi_bvalid) begin
         awh_d = 1'b0;
         wh_d = 1'b0;
         bv_d = 1'b1;
         br_d = RESP_OKAY;
         if (awa_q == OFS_CTRL) begin
            if (ws_q) begin
               ctrl_en_d = wd_q[CTRL_LINK_EN];
            end
         end else if (awa_q != OFS_STATUS) begin
            br_d = RESP_SLVERR;
         end
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rr_d = RESP_OKAY;
         rdat_d = 32'h0;
         if (s_axi_araddr == OFS_CTRL) begin
            rdat_d[CTRL_LINK_EN] = ctrl_en_q;
         end else if (s_axi_araddr == OFS_STATUS) begin
            rdat_d = status;
         end else begin
            rr_d = RESP_SLVERR;
         end
      end
      awr_d = !awh_d && !bv_d;
      wr_d = !wh_d && !bv_d;
      arr_d = !rv_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awh_q <= 1'b0;
         awa_q <= 8'h00;
         wh_q <= 1'b0;
         wd_q <= 32'h0;
         ws_q <= 1'b0;
         ctrl_en_q <= CTRL_LINK_EN_RST;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         awh_q <= awh_d;
         awa_q <= awa_d;
         wh_q <= wh_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         ctrl_en_q <= ctrl_en_d;
         s_axi_awready <= awr_d;
         s_axi_wready <= wr_d;
         s_axi_bvalid <= bv_d;
         s_axi_bresp <= br_d;
         s_axi_arready <= arr_d;
         s_axi_rvalid <= rv_d;
         s_axi_rdata <= rdat_d;
         s_axi_rresp <= rr_d;
      end
   end
endmodule // srtc_access

// >>> sim/srtc_access_chk.sv
// assertions on the link and power pins of the access block
`timescale 1ns/1ps
module srtc_access_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic power_fail,
   input wire logic on_battery,
   input wire logic rst_out,
   input wire logic rst_out_oe
);
   logic sck_q, sck_d;
   logic [7:0] age_q, age_d;
   // cycles since the serial clock was seen falling
   always_comb begin
      sck_d = spi_sck;
      age_d = (age_q == 8'hFF) ? age_q : age_q + 8'h01;
      if (sck_q && !spi_sck) begin
         age_d = 8'h00;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sck_q <= 1'b0;
         age_q <= 8'hFF;
      end else begin
         sck_q <= sck_d;
         age_q <= age_d;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_desel;
      spi_cs_n [*4];
   endsequence
   sequence s_pf_held;
      (power_fail && !on_battery) [*3];
   endsequence
   chk_oe_desel: assert property (s_desel |-> !serial_out_oe)
      else $error("output driven while deselected");
   chk_out_on_fall: assert property (serial_out_oe && $past(serial_out_oe) &&
      $changed(serial_out) |-> age_q <= 8'h06) else $error("output moved off a falling edge");
   chk_out_hold_hi: assert property ($rose(spi_sck) && serial_out_oe |=>
      $stable(serial_out) [*8]) else $error("output moved after a rising edge");
   chk_oe_on_fall: assert property ($rose(serial_out_oe) |-> age_q <= 8'h06)
      else $error("output enabled off a falling edge");
   chk_pf_reset: assert property (s_pf_held |-> rst_out_oe)
      else $error("reset not driven on power fail");
   chk_rec_hold: assert property ($fell(power_fail) && !on_battery |=> rst_out_oe [*8])
      else $error("reset released before recovery");
   chk_batt_hiz: assert property (on_battery [*4] |-> !serial_out_oe && !rst_out_oe)
      else $error("output driven on battery");
   chk_pf_abort: assert property (power_fail [*3] |-> !serial_out_oe)
      else $error("link active during power fail");
   chk_rst_low: assert property (rst_out_oe |-> !rst_out)
      else $error("reset pin driven high");
endmodule // srtc_access_chk
bind srtc_access srtc_access_chk srtc_access_chk_inst (
   .aclk, .aresetn, .spi_sck, .spi_cs_n, .serial_out, .serial_out_oe,
   .power_fail, .on_battery, .rst_out, .rst_out_oe
);

// >>> sim/srtc_spi_master.sv
// serial link master model for the access block
`timescale 1ns/1ps
module srtc_spi_master #(
   parameter int HALF = 40
) (
   input wire logic aclk,
   output logic spi_sck,
   output logic spi_cs_n,
   output logic serial_in,
   input wire logic sdo_line
);
   logic mode3 = 1'b0;
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      serial_in = 1'b0;
   end
   // idle clock level, deselect time, then falling enable
   task automatic frame_begin(input logic m3);
      @(posedge aclk);
      mode3 <= m3;
      spi_sck <= m3;
      repeat (HALF) @(posedge aclk);
      spi_cs_n <= 1'b0;
      repeat (HALF) @(posedge aclk);
   endtask
   // msb first, change low, sample on rise
   task automatic xbits(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         spi_sck <= 1'b0;
         serial_in <= tx[i];
         repeat (HALF) @(posedge aclk);
         spi_sck <= 1'b1;
         rx[i] = sdo_line;
         repeat (HALF) @(posedge aclk);
      end
   endtask
   // enable high ends the burst, data line inverted
   task automatic frame_end;
      spi_sck <= mode3;
      repeat (HALF) @(posedge aclk);
      spi_cs_n <= 1'b1;
      serial_in <= ~serial_in;
   endtask
endmodule // srtc_spi_master

// >>> sim/tb.sv
// self-checking bench for the serial clock/calendar access block
`timescale 1ns/1ps
module tb;
   import srtc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, power_fail = 1'b0, on_battery = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, d;
   logic spi_sck, spi_cs_n, serial_in, serial_out, serial_out_oe, rst_out, rst_out_oe;
   logic [7:0] rxb [8];
   logic [7:0] junk;
   wire sdo_line;
   int err_count = 0;
   int total_checks = 0;
   assign sdo_line = serial_out_oe ? serial_out : ~serial_out;
   always #2.5 aclk = ~aclk;
   srtc_access #(.TICK_CYC(20), .REC_CYC(10)) srtc_access_inst (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .spi_sck, .spi_cs_n, .serial_in,
      .serial_out, .serial_out_oe, .power_fail, .on_battery, .rst_out, .rst_out_oe);
   srtc_spi_master #(.HALF(40)) srtc_spi_master_inst (
      .aclk, .spi_sck, .spi_cs_n, .serial_in, .sdo_line);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      chk(32'(s_axi_rresp), 32'(er));
   endtask
   task automatic frame(input logic m3, input logic [7:0] cmd, input logic [63:0] tx, int n);
      srtc_spi_master_inst.frame_begin(m3);
      srtc_spi_master_inst.xbits(cmd, 8, junk);
      for (int k = 0; k < n; k++) begin
         srtc_spi_master_inst.xbits(tx[63-8*k -: 8], 8, rxb[k]);
      end
      srtc_spi_master_inst.frame_end();
   endtask
   task automatic t_regs;
      axi_rd(OFS_CTRL, RESP_OKAY);
      chk(d & 32'h1, 32'(CTRL_LINK_EN_RST));
      axi_wr(OFS_STATUS, 32'hFFF, RESP_OKAY);
      axi_rd(OFS_STATUS, RESP_OKAY);
      chk(d & 32'hFFF, 32'h0);
      axi_rd(8'h08, RESP_SLVERR);
      axi_wr(8'h0C, 32'h0, RESP_SLVERR);
      frame(1'b0, 8'h90, 64'h3C00_0000_0000_0000, 1);
      axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
      frame(1'b0, 8'h90, 64'h1100_0000_0000_0000, 1);
      axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
      frame(1'b0, 8'h10, 64'h0, 1);
      chk(32'(rxb[0]), 32'h3C);
   endtask
   task automatic t_wrap;
      frame(1'b0, 8'hFF, 64'h5A00_8000_0000_0000, 3);
      frame(1'b1, 8'h3F, 64'h0, 3);
      chk(32'(rxb[0]), 32'h5A);
      chk(32'(rxb[2]), 32'h80);
      axi_rd(OFS_STATUS, RESP_OKAY);
      chk(32'(d[STAT_OSC_STOP]), 32'h1);
   endtask
   task automatic t_freeze;
      srtc_spi_master_inst.frame_begin(1'b0);
      srtc_spi_master_inst.xbits(8'h00, 8, junk);
      srtc_spi_master_inst.xbits(8'h00, 8, junk);
      axi_rd(OFS_STATUS, RESP_OKAY);
      chk(d & 32'h7F, 32'h41);
      for (int k = 0; k < 7; k++) begin
         srtc_spi_master_inst.xbits(8'h00, 8, junk);
      end
      axi_rd(OFS_STATUS, RESP_OKAY);
      chk(d & 32'h7F, 32'h08);
      srtc_spi_master_inst.frame_end();
   endtask
   task automatic t_century;
      frame(1'b0, 8'h80, 64'h99D9_59A3_0731_1299, 8);
      frame(1'b0, 8'h81, 64'h5900_0000_0000_0000, 1);
      frame(1'b1, 8'h03, 64'h0, 5);
      chk(32'(rxb[0]), 32'hC0);
      chk(32'({rxb[2], rxb[3], rxb[4]}), 32'h010100);
      axi_rd(OFS_STATUS, RESP_OKAY);
      chk(32'(d[STAT_CENT_FLAG]), 32'h1);
   endtask
   task automatic t_power;
      srtc_spi_master_inst.frame_begin(1'b0);
      srtc_spi_master_inst.xbits(8'h90, 8, junk);
      srtc_spi_master_inst.xbits(8'hE7, 4, junk);
      power_fail <= 1'b1;
      repeat (5) @(posedge aclk);
      chk(32'(rst_out_oe), 32'h1);
      axi_rd(OFS_STATUS, RESP_OKAY);
      chk(d & 32'h23F, 32'h200);
      srtc_spi_master_inst.xbits(8'h70, 4, junk);
      power_fail <= 1'b0;
      repeat (20) @(posedge aclk);
      chk(32'(rst_out_oe), 32'h0);
      axi_rd(OFS_STATUS, RESP_OKAY);
      chk(d & 32'h280, 32'h0);
      srtc_spi_master_inst.frame_end();
      frame(1'b0, 8'h10, 64'h0, 1);
      chk(32'(rxb[0]), 32'h3C);
      power_fail <= 1'b1;
      @(posedge aclk);
      on_battery <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(32'({rst_out_oe, serial_out_oe}), 32'h0);
      on_battery <= 1'b0;
      repeat (6) @(posedge aclk);
      power_fail <= 1'b0;
      repeat (20) @(posedge aclk);
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_wrap();
      t_freeze();
      t_century();
      t_power();
      finish_test();
   end
   initial begin
      #400_000;
      err_count++;
      finish_test();
   end
endmodule // tb
